// ==== rtl/call_gate_privilege_check.sv ====
// far call and far jump through a call gate: sequencing, apb registers, results
// Overview of operation
// - gate descriptors from the interrupt table are refused with a protection fault.
// - gate size sets push width: 16-bit gate pushes words, 32-bit doublewords.
// - a gate or target with present bit clear raises the not-present fault.
// - parameter count is words or doublewords by gate size, used only on switch.
// - at most 31 parameters are copied between stacks.
// - long gate bytes 11:8 give offset bits 63:32; non-canonical offset faults.
// - long gate upper type field bits 12:8 must be zero, else protection fault.
// - long gate is sixteen bytes, fetched as two descriptor words.
// - long gate target must have long bit set and size bit clear.
// - in long mode type 0CH is the 64-bit gate; no 32-bit gate.
// - type 04H referenced in long mode raises a protection fault.
// - long gates push eight bytes, full pointer, and copy no parameters.
// - only the far pointer selector locates the gate; its offset is ignored.
// - target descriptor comes from gate selector; entry is base plus gate offset.
// - current level must not exceed the gate's privilege level.
// - selector requestor level must not exceed the gate's privilege level.
// - calls need target privilege level at or below the current level.
// - jumps to nonconforming targets need target level equal to current level.
// - calls and jumps may reach conforming targets at or below current level.
// - call to inner nonconforming target lowers current level and requests stack switch.
// - conforming targets keep the current level and need no stack switch.
//
// Design decisions made here: the APB register port and the register addresses.
module call_gate_privilege_check
   import call_gate_pkg::*;
#(
   parameter int unsigned VA_BITS = VA_BITS_DEF
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic xfer_valid_i,
   output logic xfer_ready_o,
   input wire logic xfer_is_call_i,
   input wire logic [15:0] xfer_selector_i,
   output logic desc_req_o,
   output logic [15:0] desc_sel_o,
   output logic desc_upper_o,
   input wire logic desc_valid_i,
   input wire logic [63:0] desc_data_i,
   input wire logic [1:0] desc_table_i,
   output logic done_o,
   output logic [1:0] fault_o,
   output logic [15:0] fault_sel_o,
   output logic [15:0] target_cs_o,
   output logic [63:0] wide_instruction_pointer_o,
   output logic [63:0] entry_addr_o,
   output logic [1:0] current_privilege_level_o,
   output logic stack_switch_o,
   output logic [3:0] push_bytes_o,
   output logic [4:0] param_count_o
);
   state_t state;
   logic long_mode;
   logic long_q;
   logic is_call_q;
   logic [15:0] sel_q;
   logic [63:0] gate_lo_q;
   logic [63:0] gate_hi_q;
   logic [63:0] code_q;
   logic [1:0] gate_tbl_q;
   logic [1:0] code_tbl_q;
   logic last_switch;
   logic apb_setup;
   logic apb_write;
   logic addr_hit;
   logic finish_ok;

   gate_check_if chk ();

   gate_privilege_eval #(
      .VA_BITS(VA_BITS)
   ) u_eval (
      .chk(chk.chk_mp)
   );

   assign chk.gate_lo = gate_lo_q;
   assign chk.gate_hi = gate_hi_q;
   assign chk.code_desc = code_q;
   assign chk.gate_tbl = gate_tbl_q;
   assign chk.code_tbl = code_tbl_q;
   assign chk.current_privilege_level = current_privilege_level_o;
   assign chk.requestor_privilege_level = sel_q[1:0];
   assign chk.is_call = is_call_q;
   assign chk.long_mode = long_q;

   // apb slave: zero wait states, read data staged during setup
   assign apb_setup = psel_i && !penable_i;
   assign apb_write = psel_i && penable_i && pwrite_i;
   assign addr_hit = (paddr_i == ADDR_CONTROL) || (paddr_i == ADDR_PRIV) ||
                     (paddr_i == ADDR_STATUS);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_hit;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (apb_setup) begin
         prdata_o <= 32'h0000_0000;
         case (paddr_i)
            ADDR_CONTROL: begin
               prdata_o[CTRL_LONG_BIT] <= long_mode;
            end
            ADDR_PRIV: begin
               prdata_o[1:0] <= current_privilege_level_o;
            end
            ADDR_STATUS: begin
               prdata_o[STATUS_BUSY_BIT] <= (state != ST_IDLE);
               prdata_o[STATUS_FAULT_LSB +: 2] <= fault_o;
               prdata_o[STATUS_SWITCH_BIT] <= last_switch;
               prdata_o[STATUS_SEL_LSB +: 16] <= fault_sel_o;
            end
            default: begin
               prdata_o <= 32'h0000_0000;
            end
         endcase
      end
   end

   // mode is sampled per transfer, so a write mid-transfer cannot split a decode
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         long_mode <= CTRL_LONG_RST;
      end else if (apb_write && paddr_i == ADDR_CONTROL) begin
         long_mode <= pwdata_i[CTRL_LONG_BIT];
      end
   end

   assign finish_ok = (state == ST_EVAL_CODE) && (chk.code_fault == FAULT_NONE);

   // a completing transfer wins over a software write in the same cycle
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         current_privilege_level_o <= CPL_RST;
      end else if (finish_ok) begin
         current_privilege_level_o <= chk.new_cpl;
      end else if (apb_write && paddr_i == ADDR_PRIV) begin
         current_privilege_level_o <= pwdata_i[1:0];
      end
   end

   assign xfer_ready_o = (state == ST_IDLE);
   assign desc_req_o = (state == ST_GATE_LO) || (state == ST_GATE_HI) || (state == ST_CODE);

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         sel_q <= 16'h0000;
         is_call_q <= 1'b0;
         long_q <= 1'b0;
         desc_sel_o <= 16'h0000;
         desc_upper_o <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (xfer_valid_i) begin
                  sel_q <= xfer_selector_i;
                  is_call_q <= xfer_is_call_i;
                  long_q <= long_mode;
                  desc_sel_o <= xfer_selector_i;
                  desc_upper_o <= 1'b0;
                  state <= ST_GATE_LO;
               end
            end
            ST_GATE_LO: begin
               if (desc_valid_i && long_q) begin
                  desc_upper_o <= 1'b1;
                  state <= ST_GATE_HI;
               end else if (desc_valid_i) begin
                  state <= ST_EVAL_GATE;
               end
            end
            ST_GATE_HI: begin
               if (desc_valid_i) begin
                  desc_upper_o <= 1'b0;
                  state <= ST_EVAL_GATE;
               end
            end
            ST_EVAL_GATE: begin
               if (chk.gate_fault != FAULT_NONE) begin
                  state <= ST_IDLE;
               end else begin
                  desc_sel_o <= chk.target_sel;
                  state <= ST_CODE;
               end
            end
            ST_CODE: begin
               if (desc_valid_i) begin
                  state <= ST_EVAL_CODE;
               end
            end
            ST_EVAL_CODE: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // descriptor capture; the upper word is cleared so legacy gates see zeros
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_lo_q <= 64'h0000_0000_0000_0000;
         gate_hi_q <= 64'h0000_0000_0000_0000;
         code_q <= 64'h0000_0000_0000_0000;
         gate_tbl_q <= TBL_GDT;
         code_tbl_q <= TBL_GDT;
      end else begin
         if (state == ST_IDLE && xfer_valid_i) begin
            gate_hi_q <= 64'h0000_0000_0000_0000;
         end
         if (state == ST_GATE_LO && desc_valid_i) begin
            gate_lo_q <= desc_data_i;
            gate_tbl_q <= desc_table_i;
         end
         if (state == ST_GATE_HI && desc_valid_i) begin
            gate_hi_q <= desc_data_i;
         end
         if (state == ST_CODE && desc_valid_i) begin
            code_q <= desc_data_i;
            code_tbl_q <= desc_table_i;
         end
      end
   end

   // targets move only on success; a fault reports and leaves them alone
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
         fault_o <= FAULT_NONE;
         fault_sel_o <= 16'h0000;
         target_cs_o <= 16'h0000;
         wide_instruction_pointer_o <= 64'h0000_0000_0000_0000;
         entry_addr_o <= 64'h0000_0000_0000_0000;
         stack_switch_o <= 1'b0;
         last_switch <= 1'b0;
         push_bytes_o <= PUSH_2;
         param_count_o <= 5'h00;
      end else begin
         done_o <= 1'b0;
         stack_switch_o <= 1'b0;
         if (state == ST_EVAL_GATE && chk.gate_fault != FAULT_NONE) begin
            done_o <= 1'b1;
            fault_o <= chk.gate_fault;
            fault_sel_o <= sel_q;
            last_switch <= 1'b0;
         end else if (state == ST_EVAL_CODE && !finish_ok) begin
            done_o <= 1'b1;
            fault_o <= chk.code_fault;
            fault_sel_o <= chk.target_sel;
            last_switch <= 1'b0;
         end else if (finish_ok) begin
            done_o <= 1'b1;
            fault_o <= FAULT_NONE;
            fault_sel_o <= 16'h0000;
            target_cs_o <= chk.target_sel;
            wide_instruction_pointer_o <= chk.target_off;
            entry_addr_o <= chk.entry_addr;
            stack_switch_o <= chk.stack_switch;
            last_switch <= chk.stack_switch;
            push_bytes_o <= chk.push_bytes;
            param_count_o <= chk.param_count;
         end
      end
   end

   property p_idt_gate;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_EVAL_GATE && gate_tbl_q == TBL_IDT) |=> done_o && fault_o == FAULT_GP;
   endproperty
   a_idt_gate: assert property (p_idt_gate) else $error("interrupt gate accepted");

   property p_gate_np;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_EVAL_GATE && chk.gate_fault != FAULT_GP && !gate_lo_q[F_P])
      |=> done_o && fault_o == FAULT_NP && fault_sel_o == $past(sel_q);
   endproperty
   a_gate_np: assert property (p_gate_np) else $error("absent gate not reported");

   property p_gate_cpl;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_EVAL_GATE && current_privilege_level_o > gate_lo_q[F_DPL +: 2])
      |=> done_o && fault_o == FAULT_GP ##1 !done_o;
   endproperty
   a_gate_cpl: assert property (p_gate_cpl) else $error("gate level check missed");

   property p_gate_rpl;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_EVAL_GATE && sel_q[1:0] > gate_lo_q[F_DPL +: 2])
      |=> fault_o == FAULT_GP && state == ST_IDLE;
   endproperty
   a_gate_rpl: assert property (p_gate_rpl) else $error("requestor level check missed");

   property p_jump_nonconf;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_EVAL_CODE && !is_call_q && !code_q[F_CONF] &&
       code_q[F_DPL +: 2] != current_privilege_level_o) |=> done_o && fault_o == FAULT_GP;
   endproperty
   a_jump_nonconf: assert property (p_jump_nonconf) else $error("jump level passed");

   property p_inner_call;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (finish_ok && is_call_q && !code_q[F_CONF] &&
       code_q[F_DPL +: 2] < current_privilege_level_o)
      |=> stack_switch_o && current_privilege_level_o == $past(code_q[F_DPL +: 2]);
   endproperty
   a_inner_call: assert property (p_inner_call) else $error("no inner switch");

   property p_conf_keeps;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (finish_ok && code_q[F_CONF]) |=> !stack_switch_o &&
      current_privilege_level_o == $past(current_privilege_level_o);
   endproperty
   a_conf_keeps: assert property (p_conf_keeps) else $error("conforming level moved");

   property p_fault_keeps;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (done_o && fault_o != FAULT_NONE)
      |-> $stable(target_cs_o) && $stable(wide_instruction_pointer_o) && !stack_switch_o;
   endproperty
   a_fault_keeps: assert property (p_fault_keeps) else $error("fault moved the target");

   property p_long_push;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (finish_ok && long_q) |=> push_bytes_o == PUSH_8 && param_count_o == 5'h00;
   endproperty
   a_long_push: assert property (p_long_push) else $error("long gate push width wrong");

   property p_long_target;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_EVAL_CODE && long_q && code_q[F_P] && (!code_q[F_LONG] || code_q[F_DSIZE]))
      |=> fault_o == FAULT_GP && fault_sel_o == $past(gate_lo_q[F_SEL +: 16]);
   endproperty
   a_long_target: assert property (p_long_target) else $error("bad long target");

   property p_canon_out;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (done_o && fault_o == FAULT_NONE && $past(long_q))
      |-> (&wide_instruction_pointer_o[63:VA_BITS-1]) ||
          !(|wide_instruction_pointer_o[63:VA_BITS-1]);
   endproperty
   a_canon_out: assert property (p_canon_out) else $error("non-canonical entry");

   c_inner_call: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      done_o && stack_switch_o);
   c_jump_conf: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      finish_ok && !is_call_q && code_q[F_CONF]);
   c_not_present: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      done_o && fault_o == FAULT_NP);
   c_long_ok: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      finish_ok && long_q);

endmodule : call_gate_privilege_check

// ==== rtl/call_gate_pkg.sv ====
// constants, field layout and types shared by the call-gate checker
package call_gate_pkg;

   // virtual address width for the canonical test
   localparam int unsigned VA_BITS_DEF = 48;

   // apb register byte addresses
   localparam int unsigned ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_PRIV = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;

   // register fields and reset values
   localparam int CTRL_LONG_BIT = 0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_FAULT_LSB = 1;
   localparam int STATUS_SWITCH_BIT = 3;
   localparam int STATUS_SEL_LSB = 16;
   localparam logic CTRL_LONG_RST = 1'b0;
   localparam logic [1:0] CPL_RST = 2'h0;

   // bit positions inside a 64-bit descriptor word
   localparam int F_OFF_LO = 0;
   localparam int F_SEL = 16;
   localparam int F_BASE_LO = 16;
   localparam int F_PCOUNT = 32;
   localparam int F_TYPE = 40;
   localparam int F_CONF = 42;
   localparam int F_CODE = 43;
   localparam int F_S = 44;
   localparam int F_DPL = 45;
   localparam int F_P = 47;
   localparam int F_OFF_HI = 48;
   localparam int F_LONG = 53;
   localparam int F_DSIZE = 54;
   localparam int F_BASE_HI = 56;
   localparam int F_HI_OFF = 0;
   localparam int F_HI_TYPE = 40;

   // gate type codes
   localparam logic [3:0] TYPE_GATE16 = 4'h4;
   localparam logic [3:0] TYPE_GATE32 = 4'hC;

   // source table reported with each fetched descriptor
   localparam logic [1:0] TBL_GDT = 2'h0;
   localparam logic [1:0] TBL_LDT = 2'h1;
   localparam logic [1:0] TBL_IDT = 2'h2;

   // width of one stack push in bytes
   localparam logic [3:0] PUSH_2 = 4'h2;
   localparam logic [3:0] PUSH_4 = 4'h4;
   localparam logic [3:0] PUSH_8 = 4'h8;

   typedef enum logic [1:0] {FAULT_NONE, FAULT_GP, FAULT_NP} fault_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_GATE_LO, ST_GATE_HI, ST_EVAL_GATE, ST_CODE, ST_EVAL_CODE
   } state_t;

endpackage : call_gate_pkg

// ==== rtl/gate_check_if.sv ====
// descriptor words in, verdicts out, between sequencer and evaluator
interface gate_check_if;
   logic [63:0] gate_lo;
   logic [63:0] gate_hi;
   logic [63:0] code_desc;
   logic [1:0] gate_tbl;
   logic [1:0] code_tbl;
   logic [1:0] current_privilege_level;
   logic [1:0] requestor_privilege_level;
   logic is_call;
   logic long_mode;
   call_gate_pkg::fault_kind_t gate_fault;
   call_gate_pkg::fault_kind_t code_fault;
   logic stack_switch;
   logic [1:0] new_cpl;
   logic [3:0] push_bytes;
   logic [4:0] param_count;
   logic [15:0] target_sel;
   logic [63:0] target_off;
   logic [63:0] entry_addr;

   modport seq_mp (
      output gate_lo, gate_hi, code_desc, gate_tbl, code_tbl, current_privilege_level, requestor_privilege_level, is_call, long_mode,
      input gate_fault, code_fault, stack_switch, new_cpl, push_bytes, param_count,
      input target_sel, target_off, entry_addr
   );
   modport chk_mp (
      input gate_lo, gate_hi, code_desc, gate_tbl, code_tbl, current_privilege_level, requestor_privilege_level, is_call, long_mode,
      output gate_fault, code_fault, stack_switch, new_cpl, push_bytes, param_count,
      output target_sel, target_off, entry_addr
   );
endinterface : gate_check_if

// ==== rtl/gate_privilege_eval.sv ====
// combinational decode of gate and code descriptors and privilege verdict
module gate_privilege_eval
   import call_gate_pkg::*;
#(
   parameter int unsigned VA_BITS = VA_BITS_DEF
) (
   gate_check_if.chk_mp chk
);
   logic [3:0] g_type;
   logic [1:0] g_dpl;
   logic [1:0] c_dpl;
   logic c_conf;
   logic canon;
   logic type_ok;
   logic inner_call;
   logic [31:0] c_base;

   if (VA_BITS < 33 || VA_BITS > 64) begin : g_bad_va
      $error("VA_BITS must lie between 33 and 64");
   end

   assign g_type = chk.gate_lo[F_TYPE +: 4];
   assign g_dpl = chk.gate_lo[F_DPL +: 2];
   assign c_dpl = chk.code_desc[F_DPL +: 2];
   assign c_conf = chk.code_desc[F_CONF];
   assign c_base = {chk.code_desc[F_BASE_HI +: 8], chk.code_desc[F_BASE_LO +: 24]};
   assign chk.target_sel = chk.gate_lo[F_SEL +: 16];

   always_comb begin
      if (chk.long_mode) begin
         chk.target_off = {chk.gate_hi[F_HI_OFF +: 32], chk.gate_lo[F_OFF_HI +: 16],
                           chk.gate_lo[F_OFF_LO +: 16]};
      end else if (g_type == TYPE_GATE32) begin
         chk.target_off = {32'h0000_0000, chk.gate_lo[F_OFF_HI +: 16],
                           chk.gate_lo[F_OFF_LO +: 16]};
      end else begin
         chk.target_off = {48'h0000_0000_0000, chk.gate_lo[F_OFF_LO +: 16]};
      end
   end

   assign canon = (&chk.target_off[63:VA_BITS-1]) || !(|chk.target_off[63:VA_BITS-1]);
   // in long mode only the wide gate type is decoded; the 16-bit type is refused
   assign type_ok = chk.long_mode ? (g_type == TYPE_GATE32) :
                    (g_type == TYPE_GATE32 || g_type == TYPE_GATE16);

   always_comb begin
      chk.gate_fault = FAULT_NONE;
      if (chk.gate_tbl == TBL_IDT) begin
         chk.gate_fault = FAULT_GP;
      end else if (chk.gate_lo[F_S] || !type_ok) begin
         chk.gate_fault = FAULT_GP;
      end else if (chk.current_privilege_level > g_dpl || chk.requestor_privilege_level > g_dpl) begin
         chk.gate_fault = FAULT_GP;
      end else if (!chk.gate_lo[F_P]) begin
         chk.gate_fault = FAULT_NP;
      end else if (chk.long_mode && chk.gate_hi[F_HI_TYPE +: 5] != 5'h00) begin
         chk.gate_fault = FAULT_GP;
      end else if (chk.long_mode && !canon) begin
         chk.gate_fault = FAULT_GP;
      end
   end

   always_comb begin
      chk.code_fault = FAULT_NONE;
      if (chk.code_tbl == TBL_IDT || !chk.code_desc[F_S] || !chk.code_desc[F_CODE]) begin
         chk.code_fault = FAULT_GP;
      end else if (c_dpl > chk.current_privilege_level) begin
         chk.code_fault = FAULT_GP;
      end else if (!chk.is_call && !c_conf && c_dpl != chk.current_privilege_level) begin
         chk.code_fault = FAULT_GP;
      end else if (!chk.code_desc[F_P]) begin
         chk.code_fault = FAULT_NP;
      end else if (chk.long_mode && (!chk.code_desc[F_LONG] || chk.code_desc[F_DSIZE])) begin
         chk.code_fault = FAULT_GP;
      end
   end

   // conforming targets keep the caller's level, so no new stack is needed
   assign inner_call = chk.is_call && !c_conf && (c_dpl < chk.current_privilege_level);
   assign chk.stack_switch = inner_call;
   assign chk.new_cpl = inner_call ? c_dpl : chk.current_privilege_level;

   assign chk.push_bytes = chk.long_mode ? PUSH_8 :
                           (g_type == TYPE_GATE32) ? PUSH_4 : PUSH_2;
   // count is words or doublewords per push_bytes; long gates never copy
   assign chk.param_count = (inner_call && !chk.long_mode) ?
                            chk.gate_lo[F_PCOUNT +: 5] : 5'h00;
   assign chk.entry_addr = {32'h0000_0000, c_base} + chk.target_off;

endmodule : gate_privilege_eval

// ==== verification/desc_table_model.sv ====
// descriptor table model answering gate and code fetches
module desc_table_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic desc_req_i,
   input wire logic [15:0] desc_sel_i,
   input wire logic desc_upper_i,
   input wire logic slow_i,
   output logic desc_valid_o,
   output logic [63:0] desc_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] mem [0:15];
   logic [63:0] last;
   logic cnt;
   // idle bus shows inverted history so a stale word never passes for fresh
   assign desc_data_o = desc_valid_o ? mem[{desc_sel_i[5:3], desc_upper_i}] : ~last;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         desc_valid_o <= 1'b0;
         cnt <= 1'b0;
         last <= 64'h0;
      end else begin
         desc_valid_o <= desc_req_i && !desc_valid_o && (!slow_i || cnt);
         cnt <= ~cnt;
         if (desc_valid_o) last <= desc_data_o;
      end
   end
endmodule : desc_table_model

// ==== verification/call_gate_privilege_check_tb_top.sv ====
// random gate transfers with apb setup and result checks
module call_gate_privilege_check_tb_top import call_gate_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [ADDR_W-1:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, rd, r, off, hoff;
   logic xfer_valid_i = 1'b0, xfer_is_call_i = 1'b0, slow = 1'b0, desc_valid_i;
   logic [15:0] xfer_selector_i = '0, desc_sel_o, fault_sel_o, target_cs_o, cs = '0, fs;
   logic [63:0] desc_data_i, wide_instruction_pointer_o, entry_addr_o, wip = '0;
   logic [1:0] desc_table_i = TBL_GDT, fault_o, current_privilege_level_o, f, current_privilege_level, gdpl, requestor_privilege_level, cdpl;
   logic [3:0] push_bytes_o;
   logic [4:0] param_count_o, pc;
   logic pready_o, pslverr_o, xfer_ready_o, desc_req_o, desc_upper_o, done_o, stack_switch_o;
   logic err, conf, call, g32, gp, lng, hbad, nc, cl, cd, sw, gs;
   int failures = 0, total_checks = 0;
   call_gate_privilege_check call_gate_privilege_check_i (.sys_clk_i, .rst_n_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .xfer_valid_i, .xfer_ready_o, .xfer_is_call_i, .xfer_selector_i, .desc_req_o,
      .desc_sel_o, .desc_upper_o, .desc_valid_i, .desc_data_i, .desc_table_i, .done_o,
      .fault_o, .fault_sel_o, .target_cs_o, .wide_instruction_pointer_o, .entry_addr_o,
      .current_privilege_level_o, .stack_switch_o, .push_bytes_o, .param_count_o);
   desc_table_model desc_table_model_i (.sys_clk_i, .rst_n_i, .desc_req_i(desc_req_o),
      .desc_sel_i(desc_sel_o), .desc_upper_i(desc_upper_o), .slow_i(slow),
      .desc_valid_o(desc_valid_i), .desc_data_o(desc_data_i));
   always #5 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n == 20) failures++;
      if (n == 20) end_sim();
      {rd, err} = {prdata_o, pslverr_o};
      {psel_i, penable_i} <= 2'b00;
   endtask : apb
   task automatic xfer();
      int n;
      n = 0;
      @(posedge sys_clk_i);
      {xfer_valid_i, xfer_is_call_i, xfer_selector_i} <= {1'b1, call, 13'h1, 1'b0, requestor_privilege_level};
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (xfer_ready_o !== 1'b1 && n < 200);
      xfer_valid_i <= 1'b0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 200);
      if (n >= 200) failures++;
      if (n >= 200) end_sim();
   endtask : xfer
   function automatic logic [1:0] exp_fault();
      if (desc_table_i == TBL_IDT || (lng && !g32)) return 2'h1;
      if (current_privilege_level > gdpl || requestor_privilege_level > gdpl) return 2'h1;
      if (!gp) return 2'h2;
      if (lng && (hbad || nc)) return 2'h1;
      if (cdpl > current_privilege_level || (!call && !conf && cdpl != current_privilege_level)) return 2'h1;
      if (lng && (!cl || cd)) return 2'h1;
      return 2'h0;
   endfunction : exp_fault
   initial begin
      r = $urandom(32'h0B06);
      repeat (3) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 12'hFFC, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      repeat (400) begin
         {r, off} = {$urandom(), $urandom()};
         {cdpl, requestor_privilege_level, gdpl, current_privilege_level, conf, call, g32, lng, slow, pc} = r[17:0];
         {gp, hbad, nc, cl, cd} = {|r[19:18], &r[21:20], &r[23:22], |r[25:24], &r[27:26]};
         @(posedge sys_clk_i);
         desc_table_i <= (r[30:28] == 3'h2) ? TBL_IDT : {1'b0, r[28]};
         hoff = {32{off[31]}} ^ {16'h0, nc, 15'h0};
         desc_table_model_i.mem[2] = {off[31:16], gp, gdpl, 1'b0,
            g32 ? TYPE_GATE32 : TYPE_GATE16, 3'h0, pc, 16'h0010, off[15:0]};
         desc_table_model_i.mem[3] = {19'h0, hbad, 12'h0, hoff};
         desc_table_model_i.mem[4] = {8'h0, 1'b0, cd, cl, 5'h0, 1'b1, cdpl, 2'b11, conf,
            2'b10, off[27:4], 16'hFFFF};
         apb(1'b1, ADDR_CONTROL, {31'h0, lng});
         apb(1'b1, ADDR_PRIV, {30'h0, current_privilege_level});
         xfer();
         f = exp_fault();
         sw = f == 2'h0 && call && !conf && cdpl < current_privilege_level;
         gs = desc_table_i == TBL_IDT || (lng && !g32) || current_privilege_level > gdpl || requestor_privilege_level > gdpl || !gp ||
              (lng && (hbad || nc));
         fs = f == 2'h0 ? 16'h0000 : gs ? {13'h1, 1'b0, requestor_privilege_level} : 16'h0010;
         chk(fault_o, f);
         chk(stack_switch_o, sw);
         chk(current_privilege_level_o, sw ? cdpl : current_privilege_level);
         if (f == 2'h0) begin
            cs = 16'h0010;
            wip = lng ? {hoff, off} : g32 ? {32'h0, off} : {48'h0, off[15:0]};
            chk(push_bytes_o, lng ? PUSH_8 : g32 ? PUSH_4 : PUSH_2);
            chk(param_count_o, sw && !lng ? pc : 5'h0);
            chk(entry_addr_o, wip + off[27:4]);
         end
         chk(target_cs_o, cs);
         chk(wide_instruction_pointer_o, wip);
         chk(fault_sel_o, fs);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk(rd, {fs, 12'h000, sw, f, 1'b0});
      end
      end_sim();
   end
endmodule : call_gate_privilege_check_tb_top
